// [pkg/lbo_pkg.sv]
// Shared constants and types for the bank read/write engine
package lbo_pkg;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int DQ_W = 32;
  localparam int MASK_W = 4;
  localparam int ACOL_W = 4; // Stored column address bits per bank (one BL16 page slice)
  localparam int IDX_W = BANK_W + ACOL_W;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 16;

  // Timing, figures in their own units
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RAS_NS = 42;
  localparam int T_WR_NS = 15;
  localparam int T_DQSS_CK = 1;
  localparam int RAS_CK_RAW = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CK_RAW = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CK = (RAS_CK_RAW < 1) ? 1 : RAS_CK_RAW;
  localparam int WR_CK = (WR_CK_RAW < 1) ? 1 : WR_CK_RAW;

  // Command opcodes
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ACT = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h3,
    OP_BURST_CUT = 3'h4, // burst_cut_command
    OP_PRE = 3'h5
  } lbo_op_t;

  localparam logic AUTO_CLOSE_ON = 1'b1;
  localparam logic AUTO_CLOSE_OFF = 1'b0;

  typedef enum logic [1:0] {BL_2 = 2'h0, BL_4 = 2'h1, BL_8 = 2'h2, BL_16 = 2'h3} lbo_bl_t;
  typedef enum logic {CL_2 = 1'b0, CL_3 = 1'b1} lbo_cl_t;
  typedef enum logic [1:0] {BK_IDLE = 2'b01, BK_OPEN = 2'b10} lbo_bank_t;

  // Strobe pattern per clock: bit 0 rising half, bit 1 falling half
  localparam logic [1:0] DQS_DATA = 2'h1;
  localparam logic [1:0] DQS_LOW = 2'h0;

  typedef struct packed {
    lbo_op_t op;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic auto_close; // auto_close_on / auto_close_off
    logic all_banks; // Precharge of every bank
  } lbo_cmd_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [1:0][DQ_W-1:0] data;
    logic [1:0][MASK_W-1:0] mask;
  } lbo_pair_t;

  localparam int PAIR_W = $bits(lbo_pair_t);
endpackage

// [src/lbo_bank_ops.sv]
// Bank activation, read and write burst engine with write buffer
`timescale 1ns/100ps

// Flop FIFO with valid/ready on both sides
module lbo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
  logic [AW:0] wp_ff; // Write pointer, extra wrap bit
  logic [AW:0] rp_ff; // Read pointer, extra wrap bit
  logic full;
  logic empty;

  assign full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign empty = (wp_ff == rp_ff);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_ff[rp_ff[AW-1:0]];

  // Pointers advance only on a completed handshake
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else if (ce) begin
      if (in_valid && !full) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end

  // Data storage, no reset needed
  always_ff @(posedge clk) begin
    if (ce && in_valid && !full) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

// Function
// R01: Row must be activated before access.
// R02: Access waits activate-to-access delay.
// R03: Same bank: precharge, then row cycle.
// R04: Other banks activate, spaced bank-to-bank.
// R05: Access carries column, bank, auto-close choice.
// R06: First read pair after CAS latency.
// R07: Strobe driven with data, low preamble.
// R08: Data lines released after burst ends.
// R09: New READ after desired pairs continues gaplessly.
// R10: READ accepted on any following cycle.
// R11: Burst cut stops read at CAS latency.
// R12: Read ended before any WRITE.
// R13: Precharge truncates read, then precharge time.
// R14: Read auto-close closes row BL/2 later.
// R15: Write data captured on rising strobe.
// R16: Controller holds strobe low around write.
// R17: First write strobe near one clock.
// R18: After write burst, further data ignored.
// R19: New WRITE accepted on any cycle.
// R20: Untruncated write waits write-to-read delay.
// R21: READ truncating write keeps earlier pairs only.
// R22: Precharge truncating write keeps earlier pairs.
// R23: CL2 one clock, CL3 two clocks.
// R24: Clock enable held high during bursts.
// R25: Controller tracks banks and timers.
module lbo_bank_ops
  import lbo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire lbo_cmd_t cmd,
  input wire lbo_bl_t bl_sel,
  input wire lbo_cl_t cas_sel,
  input wire logic [1:0][DQ_W-1:0] dq_i,
  output logic [1:0][DQ_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [1:0] dqs_i,
  output logic [1:0] dqs_o,
  output logic dqs_oe,
  input wire logic [1:0][MASK_W-1:0] dm_i,
  output logic wr_buf_ready,
  output logic [BANKS-1:0] bank_open
);
  // Burst length expressed in clock cycles (data pairs)
  function automatic logic [3:0] pairs_of(input lbo_bl_t bl);
    unique case (bl)
      BL_2: pairs_of = 4'h1;
      BL_4: pairs_of = 4'h2;
      BL_8: pairs_of = 4'h4;
      BL_16: pairs_of = 4'h8;
    endcase
  endfunction

  // Next even column, wrapping inside the burst block
  function automatic logic [ACOL_W-1:0] next_col(input logic [ACOL_W-1:0] c,
                                                 input logic [3:0] pairs);
    logic [ACOL_W-1:0] wrap;
    wrap = ACOL_W'({pairs, 1'b0} - 5'h1);
    next_col = (c & ~wrap) | ((c + ACOL_W'(2)) & wrap);
  endfunction

  logic [3:0] pairs; // Current burst in pairs
  logic [DQ_W-1:0] mem_ff [BANKS << ACOL_W]; // Array slice, index {bank,col}
  lbo_bank_t bank_st_ff [BANKS]; // Idle or open per bank
  logic [ROW_W-1:0] row_ff [BANKS]; // Open row per bank
  logic [CNT_W-1:0] ras_cnt_ff [BANKS]; // Min active time left
  logic [CNT_W-1:0] close_cnt_ff [BANKS]; // Pending auto-close, 0 = none
  logic [3:0] rd_left_ff; // Read pairs still to issue
  logic [ACOL_W-1:0] rd_col_ff; // Next read column
  logic [BANK_W-1:0] rd_bank_ff; // Bank of running read
  logic slot_v; // Read pair issued this cycle
  logic [IDX_W-1:0] slot_idx; // Index of that pair
  logic s1_v_ff; // One-cycle delayed slot for CL3
  logic [IDX_W-1:0] s1_idx_ff;
  logic src_v; // Slot feeding the output flops
  logic [IDX_W-1:0] src_idx;
  logic out_v_ff; // Output pair on the pins
  logic [1:0][DQ_W-1:0] dout_ff; // Output data pair
  logic [3:0] wr_left_ff; // Write pairs still to capture
  logic [ACOL_W-1:0] wr_col_ff; // Next write column
  logic [BANK_W-1:0] wr_bank_ff; // Bank of running write
  logic cut_rd; // Running read stopped this cycle
  logic cut_wr; // Running write stopped this cycle
  logic cap; // Pair captured this cycle
  lbo_pair_t cap_pair; // Captured pair
  lbo_pair_t drain_pair; // Pair leaving the buffer
  logic drain_v;
  logic drain_rdy;

  assign pairs = pairs_of(bl_sel);

  // Truncation of a running read: cut command, write, or precharge to it
  assign cut_rd = (cmd.op == OP_BURST_CUT) || (cmd.op == OP_WRITE) || // R11
                  ((cmd.op == OP_PRE) && (cmd.all_banks || cmd.bank == rd_bank_ff)); // R13

  // Truncation of a running write by READ or precharge to it
  assign cut_wr = (cmd.op == OP_READ) || // R21
                  ((cmd.op == OP_PRE) && (cmd.all_banks || cmd.bank == wr_bank_ff)); // R22

  // Read slot: a new READ wins over a running one, so bursts chain without gaps
  always_comb begin
    slot_v = 1'b0;
    slot_idx = '0;
    if (cmd.op == OP_READ) begin
      slot_v = 1'b1; // R10
      slot_idx = {cmd.bank, cmd.col[ACOL_W-1:1], 1'b0}; // R05
    end else if (rd_left_ff != 4'h0 && !cut_rd) begin
      slot_v = 1'b1; // R09
      slot_idx = {rd_bank_ff, rd_col_ff};
    end
  end

  // Read column engine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_left_ff <= 4'h0;
      rd_col_ff <= '0;
      rd_bank_ff <= '0;
    end else if (ce) begin
      if (cmd.op == OP_READ) begin
        rd_left_ff <= pairs - 4'h1;
        rd_col_ff <= next_col({cmd.col[ACOL_W-1:1], 1'b0}, pairs);
        rd_bank_ff <= cmd.bank;
      end else if (cut_rd) begin
        rd_left_ff <= 4'h0; // R11
      end else if (rd_left_ff != 4'h0) begin
        rd_left_ff <= rd_left_ff - 4'h1;
        rd_col_ff <= next_col(rd_col_ff, pairs);
      end
    end
  end

  // Latency choice: CL2 uses the slot directly, CL3 one stage later
  assign src_v = (cas_sel == CL_2) ? slot_v : s1_v_ff; // R23
  assign src_idx = (cas_sel == CL_2) ? slot_idx : s1_idx_ff;

  // Latency delay stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_v_ff <= 1'b0;
      s1_idx_ff <= '0;
    end else if (ce) begin
      s1_v_ff <= slot_v;
      s1_idx_ff <= slot_idx;
    end
  end

  // Output pair register, data appears CL-1 clocks after READ
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_v_ff <= 1'b0;
      dout_ff <= '0;
    end else if (ce) begin
      out_v_ff <= src_v; // R06
      if (src_v) begin
        dout_ff[0] <= mem_ff[src_idx];
        dout_ff[1] <= mem_ff[src_idx | IDX_W'(1)];
      end
    end
  end

  // Pin drive; data lines float as soon as no pair is due
  assign dq_o = dout_ff;
  assign dq_oe = out_v_ff; // R08
  // Strobe low one cycle ahead as preamble, low in the last falling half
  assign dqs_oe = out_v_ff || src_v; // R07
  assign dqs_o = out_v_ff ? DQS_DATA : DQS_LOW; // R07

  // Write capture window; a strobe with no open window is ignored
  assign cap = (wr_left_ff != 4'h0) && !cut_wr && (dqs_i == DQS_DATA) && wr_buf_ready; // R15
  assign cap_pair = '{idx: {wr_bank_ff, wr_col_ff}, data: dq_i, mask: dm_i};

  // Write column engine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_left_ff <= 4'h0;
      wr_col_ff <= '0;
      wr_bank_ff <= '0;
    end else if (ce) begin
      if (cmd.op == OP_WRITE) begin
        wr_left_ff <= pairs; // R19
        wr_col_ff <= {cmd.col[ACOL_W-1:1], 1'b0};
        wr_bank_ff <= cmd.bank;
      end else if (cut_wr) begin
        wr_left_ff <= 4'h0; // R21 R22
      end else if (cap) begin
        wr_left_ff <= wr_left_ff - 4'h1; // R18
        wr_col_ff <= next_col(wr_col_ff, pairs);
      end
    end
  end

  // Buffer between strobe capture and the array; drains only when no read
  // uses the array port, so pairs already captured wait out a long read stream
  lbo_fifo #(
    .WIDTH(PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) i_lbo_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_data(cap_pair),
    .in_valid(cap),
    .in_ready(wr_buf_ready),
    .out_data(drain_pair),
    .out_valid(drain_v),
    .out_ready(drain_rdy)
  );

  assign drain_rdy = ~src_v;

  // Array write with byte masks; a high mask bit keeps the old byte
  always_ff @(posedge clk) begin
    if (ce && drain_v && drain_rdy) begin
      for (int e = 0; e < 2; e++) begin
        for (int b = 0; b < MASK_W; b++) begin
          if (!drain_pair.mask[e][b]) begin
            mem_ff[drain_pair.idx | IDX_W'(e)][b*8 +: 8] <= drain_pair.data[e][b*8 +: 8];
          end
        end
      end
    end
  end

  // Bank state: activation, precharge, and auto-close timers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_st_ff[i] <= BK_IDLE;
        row_ff[i] <= '0;
        ras_cnt_ff[i] <= '0;
        close_cnt_ff[i] <= '0;
      end
    end else if (ce) begin
      for (int i = 0; i < BANKS; i++) begin
        // Minimum active time countdown
        if (ras_cnt_ff[i] != '0) begin
          ras_cnt_ff[i] <= ras_cnt_ff[i] - 1'b1;
        end
        // Auto-close waits at its last step until active time is met
        if (close_cnt_ff[i] > CNT_W'(1)) begin
          close_cnt_ff[i] <= close_cnt_ff[i] - 1'b1;
        end else if (close_cnt_ff[i] == CNT_W'(1) && ras_cnt_ff[i] == '0) begin
          close_cnt_ff[i] <= '0;
          bank_st_ff[i] <= BK_IDLE; // R14
        end
        if (cmd.bank == BANK_W'(i)) begin
          unique case (cmd.op)
            OP_ACT: begin
              bank_st_ff[i] <= BK_OPEN;
              row_ff[i] <= cmd.row;
              ras_cnt_ff[i] <= CNT_W'(RAS_CK);
            end
            OP_READ: begin
              // Read auto-close fires BL/2 clocks after the command
              close_cnt_ff[i] <= (cmd.auto_close == AUTO_CLOSE_ON) ?
                                 CNT_W'(pairs) : '0; // R05 R14
            end
            OP_WRITE: begin
              // Write auto-close after strobe delay, burst and recovery
              close_cnt_ff[i] <= (cmd.auto_close == AUTO_CLOSE_ON) ?
                                 CNT_W'(pairs) + CNT_W'(T_DQSS_CK + WR_CK) : '0; // R05
            end
            default: begin
            end
          endcase
        end
        // Explicit precharge, one bank or all
        if (cmd.op == OP_PRE && (cmd.all_banks || cmd.bank == BANK_W'(i))) begin
          bank_st_ff[i] <= BK_IDLE;
          close_cnt_ff[i] <= '0;
        end
      end
    end
  end

  // Open status per bank
  always_comb begin
    for (int i = 0; i < BANKS; i++) begin
      bank_open[i] = (bank_st_ff[i] == BK_OPEN);
    end
  end
endmodule

// [verification/lbo_bank_ops_assertions.sv]
// Port checks for the bank engine
`timescale 1ns/100ps
module lbo_bank_ops_chk
  import lbo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire lbo_cmd_t cmd,
  input wire lbo_bl_t bl_sel,
  input wire lbo_cl_t cas_sel,
  input wire logic dq_oe,
  input wire logic [1:0] dqs_o,
  input wire logic dqs_oe,
  input wire logic [BANKS-1:0] bank_open
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !ce); // Frozen cycles prove nothing
  // Short read at the low latency
  sequence rd_short;
    cmd.op == OP_READ && bl_sel == BL_4 && cas_sel == CL_2;
  endsequence
  // Quiet command bus afterwards
  sequence quiet3;
    (cmd.op == OP_NOP) [*3];
  endsequence
  AST_ACT_OPENS: assert property (cmd.op == OP_ACT |=> bank_open[$past(cmd.bank)])
    else $error("bank stays closed after activate");
  AST_PRE_CLOSES: assert property (cmd.op == OP_PRE && !cmd.all_banks |=>
    !bank_open[$past(cmd.bank)]) else $error("bank stays open after precharge");
  AST_CL2_FIRST: assert property (cmd.op == OP_READ && cas_sel == CL_2 |=> dq_oe)
    else $error("read data late at low latency");
  AST_CL3_FIRST: assert property (cmd.op == OP_READ && cas_sel == CL_3 && !dq_oe
    |=> dqs_oe && !dq_oe ##1 dq_oe) else $error("read timing wrong at high latency");
  AST_PREAMBLE: assert property (cmd.op == OP_READ && cas_sel == CL_2 && !dq_oe
    |-> dqs_oe && dqs_o == DQS_LOW) else $error("no low strobe before read data");
  AST_STROBE_DATA: assert property (dq_oe |-> dqs_oe && dqs_o == DQS_DATA)
    else $error("strobe not driven with data");
  AST_BURST_END: assert property (rd_short ##1 quiet3 |-> $past(dq_oe) && !dq_oe)
    else $error("data lines not released after burst");
  AST_CUT: assert property (cmd.op == OP_BURST_CUT && cas_sel == CL_2 |=> !dq_oe)
    else $error("read continues after burst cut");
  AST_AUTO_CLOSE: assert property (cmd.op == OP_READ && cmd.auto_close &&
    bl_sel == BL_4 |-> ##3 !bank_open[$past(cmd.bank, 3)]) else $error("no auto close");
endmodule

bind lbo_bank_ops lbo_bank_ops_chk i_lbo_bank_ops_chk (.clk, .rst_b, .ce, .cmd, .bl_sel,
  .cas_sel, .dq_oe, .dqs_o, .dqs_oe, .bank_open);

// [verification/lbo_ctrl_model.sv]
// Controller model: commands, write data and strobe
`timescale 1ns/100ps
module lbo_ctrl_model
  import lbo_pkg::*;
(
  input wire logic clk,
  output lbo_cmd_t cmd,
  output logic [1:0][DQ_W-1:0] dq_i,
  output logic [1:0] dqs_i,
  output logic [1:0][MASK_W-1:0] dm_i
);
  // Idle bus at time zero
  initial begin
    cmd = '0;
    dq_i = '0;
    dqs_i = DQS_LOW;
    dm_i = '0;
  end
  // One clock of bus activity, changed after the falling edge
  task automatic drive(input lbo_op_t op, input logic [1:0] bk, input logic [8:0] col,
                       input logic ac, input logic stb, input logic [63:0] d,
                       input logic [7:0] m);
    // On a precharge the auto-close bit selects every bank
    cmd = '{op: op, bank: bk, row: 13'h0012, col: col, auto_close: ac,
            all_banks: (op == OP_PRE) && ac};
    dqs_i = stb ? DQS_DATA : DQS_LOW;
    dq_i = stb ? d : ~dq_i; // Released lines flip so stale data never matches
    dm_i = stb ? m : ~dm_i;
    @(negedge clk);
  endtask
endmodule

// [verification/test_lbo_bank_ops.sv]
// Self-checking bench for the bank engine
`timescale 1ns/100ps
module test_lbo_bank_ops
  import lbo_pkg::*;
;
  logic clk, rst_b, ce, dq_oe, dqs_oe, wr_buf_ready; // Clock, reset, status
  lbo_cmd_t cmd; // From controller model
  lbo_bl_t bl_sel;
  lbo_cl_t cas_sel;
  logic [1:0][DQ_W-1:0] dq_i, dq_o;
  logic [1:0] dqs_i, dqs_o;
  logic [1:0][MASK_W-1:0] dm_i;
  logic [BANKS-1:0] bank_open;
  logic [31:0] mem [64]; // Expected array, bank times 16 plus column
  logic [64:0] trace [$]; // Settled {dq_oe, dq_o} after each rising edge
  int failures, n_compared;
  lbo_bank_ops i_lbo_bank_ops (.clk, .rst_b, .ce, .cmd, .bl_sel, .cas_sel, .dq_i, .dq_o,
    .dq_oe, .dqs_i, .dqs_o, .dqs_oe, .dm_i, .wr_buf_ready, .bank_open);
  lbo_ctrl_model i_lbo_ctrl_model (.clk, .cmd, .dq_i, .dqs_i, .dm_i);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Record read bus once settled
  always @(posedge clk) begin
    #1;
    trace.push_back({dq_oe, dq_o});
  end
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic drv(lbo_op_t op, int bk, int col, logic ac, logic stb, logic [63:0] d,
                     logic [7:0] m);
    i_lbo_ctrl_model.drive(op, bk[1:0], col[8:0], ac, stb, d, m);
  endtask
  task automatic idle(int n);
    repeat (n) drv(OP_NOP, 0, 0, 0, 0, 0, 0);
  endtask
  // Strobed pairs; the last one may carry a command
  task automatic wr_pairs(int bk, int col, int n, logic [31:0] base, lbo_op_t op, int c2);
    for (int i = 0; i < n; i++) begin
      drv(i == n - 1 ? op : OP_NOP, bk, c2, 0, 1, {base + 2 * i + 1, base + 2 * i}, 0);
      mem[bk * 16 + col + 2 * i] = base + 2 * i;
      mem[bk * 16 + col + 2 * i + 1] = base + 2 * i + 1;
    end
  endtask
  // Recorded pairs against the array, then the released bus
  task automatic rd_chk(int off, int bk, int col, int n);
    for (int i = 0; i < n; i++) begin
      check(trace[off + i], {1'b1, mem[bk * 16 + col + 2 * i + 1], mem[bk * 16 + col + 2 * i]});
    end
    check(trace[off + n][64], 0);
  endtask
  task automatic rd(int bk, int col, int n);
    trace.delete();
    drv(OP_READ, bk, col, 0, 0, 0, 0);
    idle(6);
    rd_chk(int'(cas_sel), bk, col, n);
  endtask
  task automatic s_basic;
    check({bank_open, wr_buf_ready, dq_oe}, 5'h02);
    drv(OP_ACT, 1, 0, 0, 0, 0, 0);
    drv(OP_ACT, 2, 0, 0, 0, 0, 0);
    check(bank_open, 4'h6);
    drv(OP_WRITE, 1, 4, 0, 0, 0, 0);
    wr_pairs(1, 4, 2, 32'h1100_0000, OP_NOP, 0);
    drv(OP_NOP, 0, 0, 0, 1, 64'hDEAD_BEEF_DEAD_BEEF, 0);
    idle(4);
    rd(1, 4, 2);
    cas_sel = CL_3;
    idle(1);
    rd(1, 4, 2);
    cas_sel = CL_2;
  endtask
  // Gapless writes, then gapless reads
  task automatic s_concat;
    drv(OP_WRITE, 1, 0, 0, 0, 0, 0);
    wr_pairs(1, 0, 2, 32'h2200_0000, OP_WRITE, 4);
    wr_pairs(1, 4, 2, 32'h3300_0000, OP_NOP, 0);
    idle(4);
    trace.delete();
    drv(OP_READ, 1, 0, 0, 0, 0, 0);
    idle(1);
    drv(OP_READ, 1, 4, 0, 0, 0, 0);
    idle(6);
    rd_chk(0, 1, 0, 4);
    bl_sel = BL_8;
    trace.delete();
    drv(OP_READ, 1, 0, 0, 0, 0, 0);
    drv(OP_BURST_CUT, 1, 0, 0, 0, 0, 0);
    idle(6);
    rd_chk(0, 1, 0, 1);
    bl_sel = BL_4;
  endtask
  // Write cut by read with a masked byte, then by precharge
  task automatic s_trunc;
    bl_sel = BL_8; // Four pairs fill columns 8 to 15
    drv(OP_WRITE, 1, 8, 0, 0, 0, 0);
    wr_pairs(1, 8, 4, 32'h4400_0000, OP_NOP, 0);
    bl_sel = BL_4;
    idle(4);
    drv(OP_WRITE, 1, 8, 0, 0, 0, 0);
    drv(OP_NOP, 0, 0, 0, 1, 64'h5555_5555_6666_6666, 8'h01);
    drv(OP_READ, 1, 0, 0, 1, 64'h7777_7777_7777_7777, 0);
    mem[24] = {24'h66_6666, mem[24][7:0]};
    mem[25] = 32'h5555_5555;
    idle(6);
    rd(1, 8, 2);
    drv(OP_WRITE, 1, 12, 0, 0, 0, 0);
    wr_pairs(1, 12, 1, 32'h9900_0000, OP_NOP, 0);
    drv(OP_PRE, 1, 0, 0, 1, 64'h1234_5678_1234_5678, 0);
    idle(4);
    check(bank_open, 4'h4);
    drv(OP_ACT, 1, 0, 0, 0, 0, 0);
    idle(4);
    rd(1, 12, 2);
    drv(OP_READ, 1, 0, 1, 0, 0, 0);
    idle(3);
    check(bank_open, 4'h4);
    // Write auto-close: bank closes after strobe delay, burst plus recovery
    drv(OP_ACT, 1, 0, 0, 0, 0, 0);
    idle(1);
    drv(OP_WRITE, 1, 0, 1, 0, 0, 0);
    wr_pairs(1, 0, 2, 32'hAA00_0000, OP_NOP, 0);
    idle(1);
    check(bank_open, 4'h6);
    idle(1);
    check(bank_open, 4'h4);
    // Clock enable low while idle: an activate has no effect
    ce = 1'b0;
    drv(OP_ACT, 1, 0, 0, 0, 0, 0);
    check(bank_open, 4'h4);
    ce = 1'b1;
    drv(OP_ACT, 1, 0, 0, 0, 0, 0);
    check(bank_open, 4'h6);
    // Shortest burst, then precharge of every bank
    bl_sel = BL_2;
    rd(1, 8, 1);
    bl_sel = BL_4;
    drv(OP_PRE, 3, 0, 1, 0, 0, 0);
    check(bank_open, 4'h0);
  endtask
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    summarize;
  end
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    bl_sel = BL_4;
    cas_sel = CL_2;
    failures = 0;
    n_compared = 0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    s_basic;
    s_concat;
    s_trunc;
    summarize;
  end
endmodule
